//--- logic/pmw_ctrl.sv
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module pmw_ctrl #(
    parameter int NMON = pmw_pkg::NMON,
    parameter int NGPIO = pmw_pkg::NGPIO
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [pmw_pkg::AW-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic CORE_SUPPLY_OK,
    input wire logic WDT_FAIL,
    input wire logic [NMON-1:0] MONITOR_INPUT,
    input wire logic LIN_RX,
    input wire logic [NGPIO-1:0] GPIO_IN,
    output logic SUPPLY_EN,
    output logic MODULE_RST,
    output logic CPU_PWR_EN,
    output logic CPU_CLK_EN,
    output logic MEAS_EN,
    output logic HIGH_SIDE_SWITCH_ON,
    output logic [1:0] MODE
);
    typedef struct packed {
        pmw_pkg::pmw_state_type st;
        logic cyc_wake, cyc_sense, sns_match;
        logic [8:0] wen;
        logic [9:0] edge_cfg;
        logic [8:0] flags;
        logic [15:0] period, ontime, cnt;
        logic [4:0] sns_sel, sns_state, sns_prev;
        logic [2:0] fail_cnt;
        logic [63:0] buf_data;
        logic core_s1, core_s2, wdt_s1, wdt_s2, wdt_s3;
        logic hs_on, pready, pslverr;
        logic [31:0] prdata;
        logic sup_en, cpu_pwr, cpu_clk, mod_rst, meas_en;
    } pmw_ctrl_regs_type;

    // Supplies come up in Reset mode; watchdog count and buffer start clear.
    localparam pmw_ctrl_regs_type RST_VAL = '{st: pmw_pkg::ST_RESET,
        wen: pmw_pkg::WEN_RST, edge_cfg: pmw_pkg::EDGE_RST, period: pmw_pkg::PER_RST,
        ontime: pmw_pkg::ONT_RST, sup_en: 1'b1, cpu_pwr: 1'b1, mod_rst: 1'b1,
        default: '0};

    pmw_ctrl_regs_type q, d;
    pmw_wake_if wk ();
    logic setup, acc, wr, wdt_evt, low_pwr, per_end, win, sns_hit, wake;
    logic [4:0] sampled, mon_gate;
    logic [8:0] ev, clr, mask;

    pmw_wake #(.NMON(NMON), .NGPIO(NGPIO)) u_wake (
        .clk(CLK),
        .srst(SRST),
        .mon(MONITOR_INPUT),
        .lin_rx(LIN_RX),
        .gpio(GPIO_IN),
        .wk(wk.wake)
    );

    assign wk.edge_cfg = q.edge_cfg;

    function automatic logic is_low_pwr(input pmw_pkg::pmw_state_type s);
        is_low_pwr = (s == pmw_pkg::ST_STOP) || (s == pmw_pkg::ST_SLEEP);
    endfunction

    always_comb begin
        d = q;
        setup = PSEL & ~PENABLE;
        acc = PSEL & PENABLE & q.pready;
        wr = acc & PWRITE;
        d.core_s1 = CORE_SUPPLY_OK;
        d.core_s2 = q.core_s1;
        d.wdt_s1 = WDT_FAIL;
        d.wdt_s2 = q.wdt_s1;
        d.wdt_s3 = q.wdt_s2;
        wdt_evt = q.wdt_s2 & ~q.wdt_s3;
        low_pwr = is_low_pwr(q.st);

        // One timer serves sleep duration, cyclic wake and sense period.
        per_end = 1'b0;
        win = 1'b0;
        if (low_pwr & (q.cyc_wake | q.cyc_sense)) begin
            if (q.cnt >= q.period - 16'h0001) begin
                d.cnt = '0;
                per_end = 1'b1;
            end else begin
                d.cnt = q.cnt + 16'h0001;
            end
            // Window of interest is the last cycle of the switch-on time.
            win = q.cyc_sense & q.hs_on & (q.cnt == q.ontime - 16'h0001);
        end else begin
            d.cnt = '0;
        end

        // In sense mode monitor edges count only while contacts are biased.
        mon_gate = (low_pwr & q.cyc_sense) ? {5{q.hs_on}} : 5'h1F;
        sampled = wk.mon_lvl & q.sns_sel;
        sns_hit = q.sns_match ? (sampled == (q.sns_state & q.sns_sel))
                              : (sampled != q.sns_prev);
        if (win) begin
            d.sns_prev = sampled;
        end

        ev = '0;
        ev[4:0] = wk.mon_evt & mon_gate;
        ev[pmw_pkg::F_LIN] = wk.lin_evt;
        ev[pmw_pkg::F_CYC] = per_end & q.cyc_wake;
        ev[pmw_pkg::F_GPIO] = wk.gpio_evt;
        ev[pmw_pkg::F_SNS] = win & sns_hit;
        ev = ev & q.wen;

        clr = '0;
        if (wr && PADDR == pmw_pkg::A_FLAG) begin
            clr = PWDATA[8:0];
        end
        // A set in the same cycle as a clear wins; flags latch in every mode.
        d.flags = (q.flags & ~clr) | ev;

        // Stop also takes GPIO wakes; Sleep does not.
        mask = (q.st == pmw_pkg::ST_STOP) ? pmw_pkg::STOP_MASK : pmw_pkg::SLEEP_MASK;
        // Any enabled latched flag in the mode's mask wakes, regardless of which came first.
        wake = |(q.flags & mask);

        if (wr) begin
            case (PADDR)
                pmw_pkg::A_CTRL: begin
                    d.cyc_wake = PWDATA[pmw_pkg::C_CYCW];
                    d.cyc_sense = PWDATA[pmw_pkg::C_CYCS];
                    d.sns_match = PWDATA[pmw_pkg::C_SMATCH];
                end
                pmw_pkg::A_WEN: d.wen = PWDATA[8:0];
                pmw_pkg::A_EDGE: d.edge_cfg = PWDATA[9:0];
                pmw_pkg::A_PER: d.period = PWDATA[15:0];
                pmw_pkg::A_ONT: d.ontime = PWDATA[15:0];
                pmw_pkg::A_SNS: begin
                    d.sns_sel = PWDATA[4:0];
                    d.sns_state = PWDATA[pmw_pkg::SNS_STATE_LSB +: 5];
                end
                pmw_pkg::A_BUF0: d.buf_data[31:0] = PWDATA;
                pmw_pkg::A_BUF1: d.buf_data[63:32] = PWDATA;
                default: begin
                end
            endcase
        end

        case (q.st)
            pmw_pkg::ST_RESET: begin
                if (q.core_s2) begin
                    d.st = pmw_pkg::ST_ACTIVE;
                end
            end
            pmw_pkg::ST_ACTIVE: begin
                if (wdt_evt) begin
                    d.fail_cnt = q.fail_cnt + 3'h1;
                    // The fifth failure goes fail-safe instead of restarting.
                    d.st = (q.fail_cnt >= pmw_pkg::WDT_FAIL_MAX) ? pmw_pkg::ST_SLEEP
                                                                 : pmw_pkg::ST_RESET;
                end else if (wr && PADDR == pmw_pkg::A_CTRL) begin
                    // Sleep entry does not look at the LIN level at all.
                    if (PWDATA[pmw_pkg::C_MODE +: 2] == pmw_pkg::MODE_STOP) begin
                        d.st = pmw_pkg::ST_STOP;
                    end else if (PWDATA[pmw_pkg::C_MODE +: 2] == pmw_pkg::MODE_SLEEP) begin
                        d.st = pmw_pkg::ST_SLEEP;
                    end
                    d.sns_prev = wk.mon_lvl & d.sns_sel;
                end
            end
            pmw_pkg::ST_STOP: begin
                if (wake) begin
                    d.st = pmw_pkg::ST_ACTIVE;
                end
            end
            pmw_pkg::ST_SLEEP: begin
                if (wake) begin
                    // Restart as after power-on; the buffer is kept.
                    d.st = pmw_pkg::ST_RESET;
                    d.fail_cnt = '0;
                end
            end
            default: d.st = pmw_pkg::ST_RESET;
        endcase

        d.sup_en = d.st != pmw_pkg::ST_SLEEP;
        d.cpu_pwr = d.st != pmw_pkg::ST_SLEEP;
        d.cpu_clk = d.st == pmw_pkg::ST_ACTIVE;
        d.mod_rst = d.st == pmw_pkg::ST_RESET;
        d.meas_en = d.st == pmw_pkg::ST_ACTIVE;
        // Taken from the next mode, so the switch drops at the same edge as the wake.
        d.hs_on = is_low_pwr(d.st) & d.cyc_sense & (d.cnt < q.ontime);

        // Zero wait states: ready is raised for the cycle after setup.
        d.pready = setup;
        if (setup) begin
            d.pslverr = 1'b0;
            case (PADDR)
                pmw_pkg::A_CTRL: d.prdata = {27'h0, q.sns_match, q.cyc_sense, q.cyc_wake, 2'h0};
                pmw_pkg::A_WEN: d.prdata = {23'h0, q.wen};
                pmw_pkg::A_EDGE: d.prdata = {22'h0, q.edge_cfg};
                pmw_pkg::A_FLAG: d.prdata = {23'h0, q.flags};
                pmw_pkg::A_PER: d.prdata = {16'h0, q.period};
                pmw_pkg::A_ONT: d.prdata = {16'h0, q.ontime};
                pmw_pkg::A_SNS: d.prdata = {19'h0, q.sns_state, 3'h0, q.sns_sel};
                pmw_pkg::A_STAT: d.prdata = {26'h0, q.core_s2, q.fail_cnt, q.st};
                pmw_pkg::A_BUF0: d.prdata = q.buf_data[31:0];
                pmw_pkg::A_BUF1: d.prdata = q.buf_data[63:32];
                default: begin
                    d.prdata = '0;
                    d.pslverr = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            q <= RST_VAL;
        end else begin
            q <= d;
        end
    end

    assign PRDATA = q.prdata;
    assign PREADY = q.pready;
    assign PSLVERR = q.pslverr;
    assign SUPPLY_EN = q.sup_en;
    assign MODULE_RST = q.mod_rst;
    assign CPU_PWR_EN = q.cpu_pwr;
    assign CPU_CLK_EN = q.cpu_clk;
    assign MEAS_EN = q.meas_en;
    assign HIGH_SIDE_SWITCH_ON = q.hs_on;
    assign MODE = q.st;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SRST);

    AST_RESET_TO_ACTIVE: assert property (
        q.st == pmw_pkg::ST_RESET && q.core_s2 |=> q.st == pmw_pkg::ST_ACTIVE && MODULE_RST == 1'b0)
        else $error("Reset mode did not leave once the core supply was stable.");
    AST_HOLD_WITHOUT_CORE: assert property (
        q.st == pmw_pkg::ST_RESET && !q.core_s2 |=> q.st != pmw_pkg::ST_ACTIVE)
        else $error("Active mode entered without a stable core supply.");
    AST_WDT_FAILSAFE: assert property (
        q.st == pmw_pkg::ST_ACTIVE && wdt_evt && q.fail_cnt == pmw_pkg::WDT_FAIL_MAX
        |=> q.st == pmw_pkg::ST_SLEEP && !CPU_PWR_EN)
        else $error("Fifth watchdog failure did not force Sleep.");
    AST_STOP_ENTRY: assert property (
        q.st == pmw_pkg::ST_ACTIVE && !wdt_evt && wr && PADDR == pmw_pkg::A_CTRL
        && PWDATA[1:0] == pmw_pkg::MODE_STOP |=> q.st == pmw_pkg::ST_STOP && CPU_PWR_EN && !CPU_CLK_EN)
        else $error("Stop command did not stop the processor clock with power kept.");
    AST_SLEEP_NO_PWR: assert property (
        q.st == pmw_pkg::ST_SLEEP |-> !CPU_PWR_EN && !SUPPLY_EN)
        else $error("Processor powered in Sleep.");
    AST_BUF_KEPT: assert property (
        q.st == pmw_pkg::ST_SLEEP |=> q.buf_data == $past(q.buf_data))
        else $error("Retention buffer changed during Sleep.");
    AST_SLEEP_WAKE: assert property (
        q.st == pmw_pkg::ST_SLEEP && (q.flags & pmw_pkg::SLEEP_MASK) != '0
        |=> q.st == pmw_pkg::ST_RESET && MODULE_RST)
        else $error("Sleep wake did not restart through Reset.");
    AST_FLAG_SET_WINS: assert property (
        ev != '0 |=> (q.flags & $past(ev)) == $past(ev))
        else $error("Wake event lost.");
    AST_W1C: assert property (
        wr && PADDR == pmw_pkg::A_FLAG && PWDATA[0] && !ev[0] |=> !q.flags[0])
        else $error("Write one did not clear the wake flag.");
    AST_STOP_WAKE: assert property (
        q.st == pmw_pkg::ST_STOP && q.flags != '0 |=> q.st == pmw_pkg::ST_ACTIVE && CPU_CLK_EN)
        else $error("Latched wake did not end Stop.");
    AST_MEAS_ON: assert property (
        q.st == pmw_pkg::ST_ACTIVE |-> MEAS_EN)
        else $error("Measurement off in Active mode.");
    AST_HS_SENSE_ONLY: assert property (
        HIGH_SIDE_SWITCH_ON |-> q.cyc_sense && low_pwr)
        else $error("High-side switch on outside cyclic sense.");
    AST_RESET_SUPPLY: assert property (
        q.st == pmw_pkg::ST_RESET |-> SUPPLY_EN && MODULE_RST)
        else $error("Supplies off or modules released in Reset mode.");
    AST_STOP_CLOCK: assert property (
        q.st == pmw_pkg::ST_STOP |-> CPU_PWR_EN && !CPU_CLK_EN)
        else $error("Processor clock running or power lost in Stop.");
    AST_LIN_STOP_WAKE: assert property (
        q.st == pmw_pkg::ST_STOP && wk.lin_evt && q.wen[pmw_pkg::F_LIN]
        |=> q.flags[pmw_pkg::F_LIN])
        else $error("LIN activity in Stop was not latched.");
    AST_SLEEP_NO_GPIO_WAKE: assert property (
        q.st == pmw_pkg::ST_SLEEP && (q.flags & pmw_pkg::SLEEP_MASK) == '0
        |=> q.st == pmw_pkg::ST_SLEEP)
        else $error("Sleep left without a Sleep wake source.");
    AST_SLEEP_ENTRY: assert property (
        q.st == pmw_pkg::ST_ACTIVE && !wdt_evt && wr && PADDR == pmw_pkg::A_CTRL
        && PWDATA[1:0] == pmw_pkg::MODE_SLEEP |=> q.st == pmw_pkg::ST_SLEEP)
        else $error("Sleep command did not enter Sleep.");
    AST_CYCLIC_WAKE: assert property (
        per_end && q.cyc_wake && q.wen[pmw_pkg::F_CYC] |=> q.flags[pmw_pkg::F_CYC])
        else $error("Cyclic period end was not latched as a wake.");
    AST_SENSE_HIT: assert property (
        win && sns_hit && q.wen[pmw_pkg::F_SNS] |=> q.flags[pmw_pkg::F_SNS])
        else $error("Sense result at the window did not latch a wake.");
    AST_SENSE_GATE: assert property (
        low_pwr && q.cyc_sense && !q.hs_on
        |=> (q.flags[4:0] & ~$past(q.flags[4:0])) == 5'h00)
        else $error("Monitor wake latched while the high-side switch was off.");
    AST_WAKE_DEFAULTS: assert property (
        $fell(SRST) |-> q.wen == pmw_pkg::WEN_RST && !q.wen[pmw_pkg::F_LIN])
        else $error("Wake enables after reset are not the defaults.");

    COV_STOP_CYCLE: cover property (
        q.st == pmw_pkg::ST_STOP ##[1:1000] q.st == pmw_pkg::ST_ACTIVE);
    COV_SLEEP_RESTART: cover property (
        q.st == pmw_pkg::ST_SLEEP ##1 q.st == pmw_pkg::ST_RESET);
    COV_SENSE_WAKE: cover property (ev[pmw_pkg::F_SNS]);
    COV_FAILSAFE: cover property (
        q.st == pmw_pkg::ST_ACTIVE && wdt_evt && q.fail_cnt == pmw_pkg::WDT_FAIL_MAX);
endmodule
`default_nettype wire

//--- logic/pmw_pkg.sv
package pmw_pkg;
    localparam int NMON = 5;
    localparam int NGPIO = 4;
    localparam int NFLAG = 9;
    localparam int AW = 8;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_WEN = 8'h04;
    localparam logic [7:0] A_EDGE = 8'h08;
    localparam logic [7:0] A_FLAG = 8'h0C;
    localparam logic [7:0] A_PER = 8'h10;
    localparam logic [7:0] A_ONT = 8'h14;
    localparam logic [7:0] A_SNS = 8'h18;
    localparam logic [7:0] A_STAT = 8'h1C;
    localparam logic [7:0] A_BUF0 = 8'h20;
    localparam logic [7:0] A_BUF1 = 8'h24;
    localparam int C_MODE = 0;
    localparam int C_CYCW = 2;
    localparam int C_CYCS = 3;
    localparam int C_SMATCH = 4;
    localparam logic [1:0] MODE_STOP = 2'h1;
    localparam logic [1:0] MODE_SLEEP = 2'h2;
    localparam int F_LIN = 5;
    localparam int F_CYC = 6;
    localparam int F_GPIO = 7;
    localparam int F_SNS = 8;
    localparam int SNS_STATE_LSB = 8;
    localparam logic [8:0] WEN_RST = 9'h15F;
    localparam logic [8:0] STOP_MASK = 9'h1FF;
    localparam logic [8:0] SLEEP_MASK = 9'h17F;
    localparam logic [9:0] EDGE_RST = 10'h3FF;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [15:0] PER_RST = 16'h0100;
    localparam logic [15:0] ONT_RST = 16'h0010;
    localparam logic [2:0] WDT_FAIL_MAX = 3'h4;
    typedef enum logic [1:0] {ST_RESET, ST_ACTIVE, ST_STOP, ST_SLEEP} pmw_state_type;
endpackage

//--- logic/pmw_wake_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pmw_wake_if;
    logic [9:0] edge_cfg;
    logic [4:0] mon_lvl;
    logic [4:0] mon_evt;
    logic lin_evt;
    logic gpio_evt;
    modport wake (input edge_cfg, output mon_lvl, output mon_evt, output lin_evt,
        output gpio_evt);
    modport ctrl (output edge_cfg, input mon_lvl, input mon_evt, input lin_evt,
        input gpio_evt);
endinterface
`default_nettype wire

//--- logic/pmw_wake.sv
`timescale 1ns/10ps
`default_nettype none
module pmw_wake #(
    parameter int NMON = 5,
    parameter int NGPIO = 4
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [NMON-1:0] mon,
    input wire logic lin_rx,
    input wire logic [NGPIO-1:0] gpio,
    pmw_wake_if.wake wk
);
    typedef struct packed {
        logic [NMON-1:0] mon_s1, mon_s2, mon_p;
        logic lin_s1, lin_s2, lin_p;
        logic [NGPIO-1:0] gp_s1, gp_s2, gp_p;
    } pmw_wake_regs_type;

    pmw_wake_regs_type q, d;

    function automatic logic edge_hit(input logic cur, input logic prev, input logic [1:0] cfg);
        edge_hit = (cfg[0] & cur & ~prev) | (cfg[1] & ~cur & prev);
    endfunction

    always_comb begin
        d = q;
        d.mon_s1 = mon;
        d.mon_s2 = q.mon_s1;
        d.mon_p = q.mon_s2;
        d.lin_s1 = lin_rx;
        d.lin_s2 = q.lin_s1;
        d.lin_p = q.lin_s2;
        d.gp_s1 = gpio;
        d.gp_s2 = q.gp_s1;
        d.gp_p = q.gp_s2;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            // The LIN line rests recessive high, so its history starts high.
            q <= '{lin_s1: 1'b1, lin_s2: 1'b1, lin_p: 1'b1, default: '0};
        end else begin
            q <= d;
        end
    end

    // Each monitor input has its own rise, fall or both-edges selection.
    always_comb begin
        for (int i = 0; i < NMON; i++) begin
            wk.mon_evt[i] = edge_hit(q.mon_s2[i], q.mon_p[i], wk.edge_cfg[2*i +: 2]);
        end
    end

    // A falling edge on the receive line marks the start of a dominant phase.
    assign wk.lin_evt = edge_hit(q.lin_s2, q.lin_p, pmw_pkg::EDGE_FALL);
    assign wk.gpio_evt = |(q.gp_s2 ^ q.gp_p);
    assign wk.mon_lvl = q.mon_s2;
endmodule
`default_nettype wire

//--- verification/pmw_src_model.sv
`timescale 1ns/10ps
`default_nettype none
module pmw_src_model (
    input wire logic clk,
    output logic [pmw_pkg::NMON-1:0] mon,
    output logic lin_rx,
    output logic [pmw_pkg::NGPIO-1:0] gpio
);
    // The LIN line has a pull-up, so a released bus rests recessive high.
    initial begin
        mon = '0;
        lin_rx = 1'b1;
        gpio = '0;
    end
    // Wake sources are asynchronous to the controller, so every source changes alone.
    task automatic mon_flip(input logic [pmw_pkg::NMON-1:0] bits);
        @(posedge clk);
        mon <= mon ^ bits;
    endtask
    task automatic lin_pulse(input int hold);
        @(posedge clk);
        lin_rx <= 1'b0;
        repeat (hold) @(posedge clk);
        lin_rx <= 1'b1;
    endtask
    // Holding the bus dominant must not keep the controller out of Sleep.
    task automatic lin_set(input logic lvl);
        @(posedge clk);
        lin_rx <= lvl;
    endtask
    task automatic gpio_flip(input logic [pmw_pkg::NGPIO-1:0] bits);
        @(posedge clk);
        gpio <= gpio ^ bits;
    endtask
endmodule
`default_nettype wire

//--- verification/power_mode_wake_controller_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_errors++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, got, exp); end end
module power_mode_wake_controller_tb;
    logic clk, srst, psel, penable, pwrite, core_ok, wdt_fail, lin, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r, b0, b1;
    logic pready, pslverr, sup_en, mod_rst, cpu_pwr, cpu_clk, meas_en, hs_on;
    logic [1:0] mode;
    logic [4:0] mon;
    logic [3:0] gpio;
    logic [9:0] edge_w;
    int n_errors = 0;
    int n_tests = 0;
    int idx;
    logic [7:0] ra [4] = '{pmw_pkg::A_WEN, pmw_pkg::A_EDGE, pmw_pkg::A_PER, pmw_pkg::A_ONT};
    logic [31:0] rv [4] = '{32'h0000015F, 32'h000003FF, 32'h00000100, 32'h00000010};
    pmw_ctrl dut (.CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .CORE_SUPPLY_OK(core_ok), .WDT_FAIL(wdt_fail), .MONITOR_INPUT(mon), .LIN_RX(lin),
        .GPIO_IN(gpio), .SUPPLY_EN(sup_en), .MODULE_RST(mod_rst), .CPU_PWR_EN(cpu_pwr),
        .CPU_CLK_EN(cpu_clk), .MEAS_EN(meas_en), .HIGH_SIDE_SWITCH_ON(hs_on), .MODE(mode));
    pmw_src_model src (.clk(clk), .mon(mon), .lin_rx(lin), .gpio(gpio));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_mode(input logic [1:0] m, input int lim);
        for (int k = 0; k < lim && mode !== m; k++) @(posedge clk);
    endtask
    function automatic logic [8:0] exp_flag(input int s, input int i);
        if (s == 0) return 9'h001 << i;
        return (s == 1) ? 9'h001 << pmw_pkg::F_LIN : 9'h001 << pmw_pkg::F_GPIO;
    endfunction
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #100000;
        n_errors++;
        $display("FAIL t=%0t timeout reached", $time);
        end_of_test();
    end
    initial begin
        void'($urandom(32'h56cf7189));
        {srst, psel, penable, pwrite, core_ok, wdt_fail, paddr, pwdata} = '0;
        srst = 1'b1;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        `CHK(mode, 2'h0)
        `CHK({mod_rst, sup_en, meas_en}, 3'b110)
        core_ok <= 1'b1;
        wait_mode(2'h1, 20);
        `CHK(mode, 2'h1)
        `CHK({meas_en, cpu_clk, mod_rst}, 3'b110)
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, ra[i], 32'h0);
            `CHK(r, rv[i])
        end
        apb(1'b0, 8'h28, 32'h0);
        `CHK({err, r}, {1'b1, 32'h0})
        $display("test reset done");
        // One monitor input, LIN and GPIO must each wake Stop on their own, and only that flag may latch.
        apb(1'b1, pmw_pkg::A_WEN, 32'h1FF);
        for (int s = 0; s < 3; s++) begin
            idx = $urandom_range(4, 0);
            apb(1'b1, pmw_pkg::A_FLAG, 32'h1FF);
            apb(1'b1, pmw_pkg::A_CTRL, {30'h0, pmw_pkg::MODE_STOP});
            wait_mode(2'h2, 10);
            `CHK({mode, cpu_clk, cpu_pwr}, 4'b1001)
            if (s == 0) src.mon_flip(5'h01 << idx);
            else if (s == 1) src.lin_pulse(3);
            else src.gpio_flip(4'($urandom_range(14, 0) + 1));
            wait_mode(2'h1, 30);
            `CHK(mode, 2'h1)
            apb(1'b0, pmw_pkg::A_FLAG, 32'h0);
            `CHK(r[8:0], exp_flag(s, idx))
            apb(1'b1, pmw_pkg::A_FLAG, 32'h0);
            apb(1'b0, pmw_pkg::A_FLAG, 32'h0);
            `CHK(r[8:0], exp_flag(s, idx))
            apb(1'b1, pmw_pkg::A_FLAG, {23'h0, exp_flag(s, idx)});
            apb(1'b0, pmw_pkg::A_FLAG, 32'h0);
            `CHK(r[8:0], 9'h000)
        end
        $display("test stop wake done");
        idx = $urandom_range(4, 0);
        edge_w = (10'h3FF & ~(10'h3 << (2 * idx))) | (10'(pmw_pkg::EDGE_FALL) << (2 * idx));
        apb(1'b1, pmw_pkg::A_EDGE, {22'h0, edge_w});
        if (mon[idx] === 1'b1) src.mon_flip(5'h01 << idx);
        repeat (6) @(posedge clk);
        apb(1'b1, pmw_pkg::A_FLAG, 32'h1FF);
        apb(1'b1, pmw_pkg::A_CTRL, {30'h0, pmw_pkg::MODE_STOP});
        wait_mode(2'h2, 10);
        src.mon_flip(5'h01 << idx);
        repeat (12) @(posedge clk);
        `CHK(mode, 2'h2)
        src.mon_flip(5'h01 << idx);
        wait_mode(2'h1, 30);
        `CHK(mode, 2'h1)
        // The flag from the falling edge is still set, so Stop must end at once.
        apb(1'b1, pmw_pkg::A_CTRL, {30'h0, pmw_pkg::MODE_STOP});
        wait_mode(2'h2, 10);
        `CHK(mode, 2'h2)
        wait_mode(2'h1, 5);
        `CHK(mode, 2'h1)
        $display("test edge select done");
        b0 = $urandom();
        b1 = $urandom();
        apb(1'b1, pmw_pkg::A_BUF0, b0);
        apb(1'b1, pmw_pkg::A_BUF1, b1);
        apb(1'b1, pmw_pkg::A_PER, 32'h8);
        apb(1'b1, pmw_pkg::A_ONT, 32'h2);
        apb(1'b1, pmw_pkg::A_WEN, 32'h15F);
        src.lin_set(1'b0);
        repeat (6) @(posedge clk);
        apb(1'b1, pmw_pkg::A_FLAG, 32'h1FF);
        apb(1'b1, pmw_pkg::A_CTRL, 32'(1) << pmw_pkg::C_CYCW);
        apb(1'b1, pmw_pkg::A_CTRL, (32'(1) << pmw_pkg::C_CYCW) | 32'(pmw_pkg::MODE_SLEEP));
        wait_mode(2'h3, 10);
        `CHK(mode, 2'h3)
        `CHK({cpu_pwr, sup_en}, 2'b00)
        wait_mode(2'h0, 40);
        `CHK({mode, mod_rst}, 3'b001)
        src.lin_set(1'b1);
        wait_mode(2'h1, 20);
        apb(1'b0, pmw_pkg::A_BUF0, 32'h0);
        `CHK(r, b0)
        apb(1'b0, pmw_pkg::A_BUF1, 32'h0);
        `CHK(r, b1)
        $display("test sleep cyclic done");
        // Cyclic wake and a falling-only monitor would hide whether the pin wakes work.
        apb(1'b1, pmw_pkg::A_CTRL, 32'h0);
        apb(1'b1, pmw_pkg::A_EDGE, {22'h0, pmw_pkg::EDGE_RST});
        apb(1'b1, pmw_pkg::A_FLAG, 32'h1FF);
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            wdt_fail <= 1'b1;
            wait_mode((i < 4) ? 2'h0 : 2'h3, 20);
            `CHK(mode, (i < 4) ? 2'h0 : 2'h3)
            wdt_fail <= 1'b0;
            if (i < 4) wait_mode(2'h1, 20);
        end
        idx = $urandom_range(4, 0);
        src.mon_flip(5'h01 << idx);
        wait_mode(2'h0, 20);
        `CHK(mode, 2'h0)
        wait_mode(2'h1, 20);
        apb(1'b0, pmw_pkg::A_FLAG, 32'h0);
        `CHK(r[8:0], exp_flag(0, idx))
        apb(1'b1, pmw_pkg::A_FLAG, 32'h1FF);
        // The pin event reaches the flags at the very edge that Sleep is entered.
        src.mon_flip(5'h01 << $urandom_range(4, 0));
        apb(1'b1, pmw_pkg::A_CTRL, {30'h0, pmw_pkg::MODE_SLEEP});
        wait_mode(2'h3, 10);
        `CHK(mode, 2'h3)
        wait_mode(2'h0, 20);
        `CHK(mode, 2'h0)
        wait_mode(2'h1, 20);
        $display("test watchdog and sleep entry done");
        apb(1'b1, pmw_pkg::A_PER, 32'h8);
        apb(1'b1, pmw_pkg::A_ONT, 32'h2);
        apb(1'b1, pmw_pkg::A_WEN, 32'(1) << pmw_pkg::F_SNS);
        apb(1'b1, pmw_pkg::A_SNS, 32'h1);
        apb(1'b1, pmw_pkg::A_FLAG, 32'h1FF);
        apb(1'b1, pmw_pkg::A_CTRL, 32'(1) << pmw_pkg::C_CYCS);
        apb(1'b1, pmw_pkg::A_CTRL, (32'(1) << pmw_pkg::C_CYCS) | 32'(pmw_pkg::MODE_STOP));
        wait_mode(2'h2, 10);
        for (int k = 0; k < 20 && hs_on !== 1'b1; k++) @(posedge clk);
        `CHK(hs_on, 1'b1)
        repeat (30) @(posedge clk);
        `CHK(mode, 2'h2)
        src.mon_flip(5'h01);
        wait_mode(2'h1, 40);
        `CHK(mode, 2'h1)
        // Match mode wakes at the first window when the pin already shows the set state.
        apb(1'b1, pmw_pkg::A_SNS, 32'h1 | (32'(mon[0]) << pmw_pkg::SNS_STATE_LSB));
        apb(1'b1, pmw_pkg::A_FLAG, 32'h1FF);
        apb(1'b1, pmw_pkg::A_CTRL, (32'(1) << pmw_pkg::C_CYCS) | (32'(1) << pmw_pkg::C_SMATCH)
            | 32'(pmw_pkg::MODE_STOP));
        wait_mode(2'h2, 10);
        `CHK(mode, 2'h2)
        wait_mode(2'h1, 20);
        `CHK(mode, 2'h1)
        $display("test cyclic sense done");
        end_of_test();
    end
endmodule
`default_nettype wire
